/* File: tdcf_readout.sv */
// per-channel stop result queues, pending pin and serial readout
// Notes on behaviour
// - a converted stop result drives pending low and becomes readable
// - conversions overlap output; the delay only shows for isolated events
// - conversion delay follows the resolution setting
// - one queue per channel, depth 16, 8 or 4 by resolution
// - a full queue discards new stop events
// - level rises per stored event, falls per result read
// - after a full queue frees space, next two events only restart it
// - pending returns high once no queue offers a converted result
// - without joint drain the four queues work independently
// - block drain offers a queue only once it is full
// - block drain ignores events while read, then skips two to restart
// - block drain starts no new block before the queue is empty
// - joint drain keeps pending high until every active queue holds data
// - block drain and joint drain may be combined
// - opcodes 0x30 reset, 0x18 init, 0x80 plus address config write
// - channel n reference bytes then stop bytes from address 8, msb first
// - reads 0x60 results, 0x40 config, address auto increments
// - empty channel reads as marker 0xfffff for both values
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module tdcf_readout #(
    parameter int MAXD = tdcf_pkg::MAXD
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] stop_valid,
    input wire tdcf_pkg::tdcf_result_t [3:0] stop_data,
    input wire logic serial_select_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic pending_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed
    {
        tdcf_pkg::tdcf_result_t [3:0][MAXD-1:0] mem;
        logic [3:0][$clog2(MAXD)-1:0] wptr;
        logic [3:0][$clog2(MAXD)-1:0] rptr;
        logic [3:0][4:0] level;
        logic [3:0][4:0] ready;
        logic [3:0][7:0] conv_cnt;
        logic [3:0][1:0] skip;
        logic [3:0] was_full;
        logic [3:0] draining;
        logic gate;
        logic running;
        logic pend_n;
        logic [7:0] ctrl;
        logic [tdcf_pkg::CFG_N-1:0][7:0] cfg;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic ssn_s1;
        logic ssn_s2;
        logic mosi_s1;
        logic mosi_s2;
        tdcf_pkg::tdcf_spi_t mode;
        logic [2:0] bitcnt;
        logic [6:0] sh;
        logic [4:0] addr;
        logic miso;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tdcf_state_t;

    tdcf_state_t s_reg;
    tdcf_state_t s_next;
    logic blk;
    logic jnt;
    logic [1:0] res;
    logic [3:0] en;
    logic [4:0] depth;
    logic [7:0] conv_load;
    logic [3:0] avail;
    logic [3:0] offered;
    logic [3:0] pop;
    logic clr_q;
    logic sclk_rise;
    logic [7:0] byte_in;
    logic [1:0] rd_ch;
    logic [2:0] rd_pos;
    logic [7:0] rd_byte;
    logic wr_go;
    logic rd_go;
    tdcf_pkg::tdcf_result_t [3:0] head;

    function automatic logic [1:0] ch_of(input logic [4:0] a);
        logic [4:0] d;
        d = a - tdcf_pkg::RES_BASE;
        ch_of = 2'(d / tdcf_pkg::RES_STRIDE);
    endfunction

    function automatic logic [2:0] pos_of(input logic [4:0] a);
        logic [4:0] d;
        d = a - tdcf_pkg::RES_BASE;
        pos_of = 3'(d % tdcf_pkg::RES_STRIDE);
    endfunction

    function automatic logic [7:0] res_byte(input logic [2:0] k, input tdcf_pkg::tdcf_result_t r, input logic v);
        logic [19:0] w;
        w = (k < 3'h3) ? r.reference_period_count : r.stop_time_result;
        if (!v)
            w = tdcf_pkg::EMPTY_MARK;
        case (k)
            3'h0, 3'h3: res_byte = {4'h0, w[19:16]};
            3'h1, 3'h4: res_byte = w[15:8];
            default: res_byte = w[7:0];
        endcase
    endfunction

    assign blk = s_reg.ctrl[tdcf_pkg::CTRL_BLOCK];
    assign jnt = s_reg.ctrl[tdcf_pkg::CTRL_JOINT];
    assign res = s_reg.ctrl[tdcf_pkg::CTRL_RES +: 2];
    assign en = s_reg.ctrl[tdcf_pkg::CTRL_EN +: 4];
    assign depth = 5'(MAXD >> ((res == 2'h3) ? 2'h2 : res));
    assign conv_load = (res == 2'h0) ? tdcf_pkg::CONV_CYC_OFF :
        (res == 2'h1) ? tdcf_pkg::CONV_CYC_2X : tdcf_pkg::CONV_CYC_4X;
    // only the second stage is looked at, the third only delays it for the edge
    assign sclk_rise = s_reg.sclk_s2 & ~s_reg.sclk_s3;
    assign byte_in = {s_reg.sh, s_reg.mosi_s2};
    assign rd_ch = ch_of(s_reg.addr);
    assign rd_pos = pos_of(s_reg.addr);
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_reg.bvalid;
    assign rd_go = s_axi_arvalid & ~s_reg.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = s_reg.rdata;
    assign miso = s_reg.miso;
    assign miso_oe = ~s_reg.ssn_s2;
    assign pending_n = s_reg.pend_n;

    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            head[c] = s_reg.mem[c][s_reg.rptr[c]];
            avail[c] = (s_reg.ready[c] != 5'h0) && (!blk || s_reg.draining[c]);
            offered[c] = avail[c] & (s_reg.gate | ~jnt);
        end
        case (s_reg.mode)
            tdcf_pkg::SPI_RDRES: rd_byte = (s_reg.addr >= tdcf_pkg::RES_BASE) ?
                res_byte(rd_pos, head[rd_ch], offered[rd_ch]) : 8'h00;
            tdcf_pkg::SPI_RDCFG: rd_byte = (s_reg.addr < tdcf_pkg::CFG_N) ? s_reg.cfg[s_reg.addr] : 8'h00;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        s_next = s_reg;
        pop = 4'h0;
        clr_q = 1'b0;
        s_next.sclk_s1 = sclk;
        s_next.sclk_s2 = s_reg.sclk_s1;
        s_next.sclk_s3 = s_reg.sclk_s2;
        s_next.ssn_s1 = serial_select_n;
        s_next.ssn_s2 = s_reg.ssn_s1;
        s_next.mosi_s1 = mosi;
        s_next.mosi_s2 = s_reg.mosi_s1;
        if (s_reg.ssn_s2)
        begin
            s_next.bitcnt = 3'h0;
            s_next.mode = tdcf_pkg::SPI_OPC;
        end
        else if (sclk_rise)
        begin
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            s_next.sh = byte_in[6:0];
            s_next.miso = rd_byte[3'h7 - s_reg.bitcnt];
            if (s_reg.bitcnt == 3'h7)
            begin
                s_next.addr = s_reg.addr + 5'h1;
                case (s_reg.mode)
                    tdcf_pkg::SPI_OPC:
                    begin
                        s_next.addr = byte_in[4:0];
                        s_next.mode = tdcf_pkg::SPI_NOP;
                        if (byte_in[7] == tdcf_pkg::OPC_WR_CFG[7])
                            s_next.mode = tdcf_pkg::SPI_WR;
                        else if (byte_in[7:5] == tdcf_pkg::OPC_RD_RES[7:5])
                            s_next.mode = tdcf_pkg::SPI_RDRES;
                        else if (byte_in[7:5] == tdcf_pkg::OPC_RD_CFG[7:5])
                            s_next.mode = tdcf_pkg::SPI_RDCFG;
                        else if (byte_in == tdcf_pkg::OPC_POWER)
                        begin
                            clr_q = 1'b1;
                            s_next.cfg = '0;
                            s_next.running = 1'b0;
                        end
                        else if (byte_in == tdcf_pkg::OPC_INIT)
                        begin
                            clr_q = 1'b1;
                            s_next.running = 1'b1;
                        end
                    end
                    tdcf_pkg::SPI_WR:
                    begin
                        if (s_reg.addr < tdcf_pkg::CFG_N)
                            s_next.cfg[s_reg.addr] = byte_in;
                    end
                    tdcf_pkg::SPI_RDRES:
                    begin
                        if (s_reg.addr >= tdcf_pkg::RES_BASE && rd_pos == tdcf_pkg::RES_LAST_POS)
                            pop[rd_ch] = offered[rd_ch];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        for (int c = 0; c < 4; c++)
        begin
            if (s_reg.conv_cnt[c] != 8'h0)
            begin
                s_next.conv_cnt[c] = s_reg.conv_cnt[c] - 8'h1;
                if (s_reg.conv_cnt[c] == 8'h1)
                    s_next.ready[c] = s_reg.ready[c] + 5'h1;
            end
            if (pop[c])
            begin
                s_next.rptr[c] = s_reg.rptr[c] + 1'b1;
                s_next.level[c] = s_next.level[c] - 5'h1;
                s_next.ready[c] = s_next.ready[c] - 5'h1;
                if (blk && s_reg.level[c] == 5'h1)
                begin
                    s_next.draining[c] = 1'b0;
                    s_next.skip[c] = tdcf_pkg::RESTART_SKIP;
                end
                // restart after full
                // a full queue arms the restart even when no event was dropped
                else if (!blk && (s_reg.was_full[c] || s_reg.level[c] >= depth))
                begin
                    s_next.was_full[c] = 1'b0;
                    s_next.skip[c] = tdcf_pkg::RESTART_SKIP;
                end
            end
            if (stop_valid[c] && s_reg.running && en[c])
            begin
                if (s_next.skip[c] != 2'h0)
                    s_next.skip[c] = s_next.skip[c] - 2'h1;
                else if (blk && s_next.draining[c])
                begin
                end
                else if (s_next.level[c] >= depth)
                    s_next.was_full[c] = ~blk;
                else
                begin
                    s_next.mem[c][s_reg.wptr[c]] = stop_data[c];
                    s_next.wptr[c] = s_reg.wptr[c] + 1'b1;
                    s_next.level[c] = s_next.level[c] + 5'h1;
                    // a result still in conversion is released early: no delay inside a burst
                    if (s_next.conv_cnt[c] != 8'h0)
                        s_next.ready[c] = s_next.ready[c] + 5'h1;
                    s_next.conv_cnt[c] = conv_load;
                    if (blk && s_next.level[c] == depth)
                        s_next.draining[c] = 1'b1;
                end
            end
            if (clr_q)
            begin
                s_next.wptr[c] = '0;
                s_next.rptr[c] = '0;
                s_next.level[c] = 5'h0;
                s_next.ready[c] = 5'h0;
                s_next.conv_cnt[c] = 8'h0;
                s_next.skip[c] = 2'h0;
                s_next.was_full[c] = 1'b0;
                s_next.draining[c] = 1'b0;
            end
        end
        // host reads channels in turn; gate does not police the order
        // closed outside joint drain, so switching it on never inherits an open gate
        if (!jnt)
            s_next.gate = 1'b0;
        else if ((&(avail | ~en)) && (|en))
            s_next.gate = 1'b1;
        else if (!(|avail))
            s_next.gate = 1'b0;
        s_next.pend_n = ~(|offered);
        if (wr_go)
        begin
            s_next.bvalid = 1'b1;
            s_next.bresp = tdcf_pkg::RESP_OKAY;
            if (s_axi_awaddr == tdcf_pkg::REG_CTRL)
            begin
                if (s_axi_wstrb[0])
                    s_next.ctrl = s_axi_wdata[7:0];
            end
            else if (s_axi_awaddr != tdcf_pkg::REG_STATUS)
                s_next.bresp = tdcf_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_next.bvalid = 1'b0;
        if (rd_go)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp = tdcf_pkg::RESP_OKAY;
            if (s_axi_araddr == tdcf_pkg::REG_CTRL)
                s_next.rdata = 32'(s_reg.ctrl);
            else if (s_axi_araddr == tdcf_pkg::REG_STATUS)
                s_next.rdata = 32'({s_reg.draining, ~s_reg.pend_n, s_reg.running, s_reg.level});
            else
            begin
                s_next.rdata = 32'h0;
                s_next.rresp = tdcf_pkg::RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            s_next.rvalid = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.ctrl <= tdcf_pkg::CTRL_RST;
            s_reg.ssn_s1 <= 1'b1;
            s_reg.ssn_s2 <= 1'b1;
            s_reg.pend_n <= 1'b1;
            s_reg.mode <= tdcf_pkg::SPI_OPC;
        end
        else
            s_reg <= s_next;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    for (genvar g = 0; g < 4; g++)
    begin : g_chk
        property p_store_inc;
            stop_valid[g] && s_reg.running && en[g] && s_reg.skip[g] == 2'h0 && !pop[g] && !clr_q
                && !(blk && s_reg.draining[g]) && s_reg.level[g] < depth
                |=> s_reg.level[g] == $past(s_reg.level[g]) + 5'h1;
        endproperty
        a_store_inc: assert property (p_store_inc) else $error("stored event did not raise level");
        property p_full_drop;
            !blk && s_reg.level[g] >= depth && stop_valid[g] && !pop[g] && !clr_q
                |=> s_reg.level[g] == $past(s_reg.level[g]);
        endproperty
        a_full_drop: assert property (p_full_drop) else $error("full queue stored an event");
        property p_restart;
            !blk && pop[g] && s_reg.was_full[g] && !clr_q && !stop_valid[g] |=> s_reg.skip[g] == 2'h2;
        endproperty
        a_restart: assert property (p_restart) else $error("restart skip not armed");
        property p_block_hold;
            blk && !s_reg.draining[g] |-> !offered[g];
        endproperty
        a_block_hold: assert property (p_block_hold) else $error("block queue offered before full");
        property p_block_read;
            blk && s_reg.draining[g] && stop_valid[g] && !pop[g] && !clr_q
                |=> s_reg.level[g] == $past(s_reg.level[g]);
        endproperty
        a_block_read: assert property (p_block_read) else $error("event stored during block read");
    end

    property p_pend;
        |offered |=> !pending_n;
    endproperty
    a_pend: assert property (p_pend) else $error("pending not low with data");
    property p_release;
        !(|offered) |=> pending_n;
    endproperty
    a_release: assert property (p_release) else $error("pending low with nothing offered");
    property p_joint;
        jnt && !s_reg.gate |=> pending_n;
    endproperty
    a_joint: assert property (p_joint) else $error("joint drain offered early");
    property p_pop_last;
        |pop |-> s_reg.mode == tdcf_pkg::SPI_RDRES && s_reg.bitcnt == 3'h7 && sclk_rise
            && rd_pos == tdcf_pkg::RES_LAST_POS;
    endproperty
    a_pop_last: assert property (p_pop_last) else $error("pop before sixth byte");

    c_full_drop: cover property (!blk && s_reg.level[0] == depth && stop_valid[0]);
    c_joint_open: cover property (jnt && $fell(pending_n));
    c_block_drain: cover property (blk && $fell(s_reg.draining[0]));
endmodule // tdcf_readout

/* File: tdcf_pkg.sv */
// shared constants and types of the tdc result queue readout block
package tdcf_pkg;
    localparam int NCH = 4;
    localparam int MAXD = 16;
    localparam int CFG_N = 17;
    localparam logic [7:0] OPC_POWER = 8'h30;
    localparam logic [7:0] OPC_INIT = 8'h18;
    localparam logic [7:0] OPC_WR_CFG = 8'h80;
    localparam logic [7:0] OPC_RD_RES = 8'h60;
    localparam logic [7:0] OPC_RD_CFG = 8'h40;
    localparam logic [4:0] RES_BASE = 5'h08;
    localparam logic [4:0] RES_STRIDE = 5'h06;
    localparam logic [2:0] RES_LAST_POS = 3'h5;
    localparam logic [19:0] EMPTY_MARK = 20'hfffff;
    localparam int CLK_MHZ = 100;
    localparam int CONV_NS_OFF = 450;
    localparam int CONV_NS_2X = 600;
    localparam int CONV_NS_4X = 900;
    localparam logic [7:0] CONV_CYC_OFF = 8'((CONV_NS_OFF * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] CONV_CYC_2X = 8'((CONV_NS_2X * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] CONV_CYC_4X = 8'((CONV_NS_4X * CLK_MHZ + 999) / 1000);
    localparam logic [1:0] RESTART_SKIP = 2'h2;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'hf0;
    localparam int CTRL_BLOCK = 0;
    localparam int CTRL_JOINT = 1;
    localparam int CTRL_RES = 2;
    localparam int CTRL_EN = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed
    {
        logic [19:0] reference_period_count;
        logic [19:0] stop_time_result;
    } tdcf_result_t;
    typedef enum logic [4:0]
    {
        SPI_OPC = 5'h01,
        SPI_WR = 5'h02,
        SPI_RDRES = 5'h04,
        SPI_RDCFG = 5'h08,
        SPI_NOP = 5'h10
    } tdcf_spi_t;
endpackage

/* File: tdcf_spi_host.sv */
// spi host model driving select, serial clock and data pins
`timescale 1ns/1ns
module tdcf_spi_host (
    output logic serial_select_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        serial_select_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic start();
        serial_select_n <= 1'b1;
        #160;
        serial_select_n <= 1'b0;
        #160;
    endtask
    // mode 1: drive in low phase, sample on falling edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosi <= tx[i];
            #80 sclk <= 1'b1;
            #80 sclk <= 1'b0;
            rx[i] = miso;
        end
        // released data line must not look stable
        mosi <= ~mosi;
    endtask
    // clock stays low between frames
    task automatic stop();
        #160 serial_select_n <= 1'b1;
    endtask
endmodule // tdcf_spi_host

/* File: test_tdc_result_fifo_readout.sv */
// self-checking bench of the tdc result queue readout block
`timescale 1ns/1ns
module test_tdc_result_fifo_readout;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] stop_valid = 4'h0;
    tdcf_pkg::tdcf_result_t [3:0] stop_data = '0;
    logic serial_select_n, sclk, mosi, miso, miso_oe, pending_n;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int fail_count = 0, tests_run = 0, dep = 16, blk = 0, jnt = 0, jg = 0;
    int skip[4];
    bit drn[4];
    logic [39:0] q[4][$];
    always #5 clk = ~clk;
    tdcf_readout tdcf_readout_i (.clk(clk), .rst_b(rst_b), .stop_valid(stop_valid), .stop_data(stop_data),
        .serial_select_n(serial_select_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .pending_n(pending_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    tdcf_spi_host tdcf_spi_host_i (.serial_select_n(serial_select_n), .sclk(sclk), .mosi(mosi), .miso(miso));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitfor(ref logic s);
        int n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 200)
            begin
                fail_count++;
                wrap_up();
            end
        end
        while (s !== 1'b1);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        waitfor(awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        waitfor(bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        waitfor(arready);
        arvalid <= 1'b0;
        waitfor(rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op, input int n, input logic [47:0] tx, output logic [47:0] rx);
        logic [7:0] b;
        tdcf_spi_host_i.start();
        tdcf_spi_host_i.xfer(op, b);
        chk(48'(miso_oe), 48'h1);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            tdcf_spi_host_i.xfer(tx[8*i+:8], b);
            rx = {rx[39:0], b};
        end
        tdcf_spi_host_i.stop();
    endtask
    function automatic bit off(input int c);
        return q[c].size() > 0 && (blk == 0 || drn[c]) && (jnt == 0 || jg != 0);
    endfunction
    task automatic upd();
        int n = 0;
        for (int c = 0; c < 4; c++)
        begin
            n += (q[c].size() > 0);
            if (blk != 0 && q[c].size() == dep)
                drn[c] = 1'b1;
        end
        if (n == 4)
            jg = 1;
        if (n == 0)
            jg = 0;
    endtask
    task automatic mode(input int res, input int bk, input int jt);
        logic [1:0] r;
        logic [47:0] x;
        axw(tdcf_pkg::REG_CTRL, 32'(8'hf0 | res << 2 | jt << 1 | bk), r);
        chk(48'(r), 48'(tdcf_pkg::RESP_OKAY));
        cmd(tdcf_pkg::OPC_INIT, 0, '0, x);
        dep = 16 >> res;
        blk = bk;
        jnt = jt;
        jg = 0;
        for (int c = 0; c < 4; c++)
        begin
            q[c].delete();
            skip[c] = 0;
            drn[c] = 1'b0;
        end
    endtask
    task automatic ev(input int c);
        logic [39:0] d;
        d[39:20] = 20'($urandom);
        d[19:0] = 20'($urandom);
        @(posedge clk);
        stop_valid[c] <= 1'b1;
        stop_data[c] <= d;
        @(posedge clk);
        stop_valid[c] <= 1'b0;
        if (!(blk != 0 && drn[c]))
        begin
            if (skip[c] > 0)
                skip[c]--;
            else if (q[c].size() < dep)
                q[c].push_back(d);
        end
        upd();
    endtask
    task automatic ck();
        logic [31:0] st;
        logic [1:0] r;
        bit p = 1'b0;
        // longest conversion is 90 cycles, pending follows one later
        repeat (100) @(posedge clk);
        axr(tdcf_pkg::REG_STATUS, st, r);
        for (int c = 0; c < 4; c++)
        begin
            chk(48'(st[5*c+:5]), 48'(q[c].size()));
            chk(48'(st[22 + c]), 48'(drn[c]));
            p |= off(c);
        end
        chk(48'(st[20]), 48'h1);
        chk(48'(pending_n), 48'(!p));
    endtask
    // reads one result of channel c, expecting the empty marker when none is offered
    task automatic rd(input int c);
        logic [47:0] v, e;
        e = {4'h0, 20'hfffff, 4'h0, 20'hfffff};
        if (off(c))
            e = {4'h0, q[c][0][39:20], 4'h0, q[c][0][19:0]};
        cmd(tdcf_pkg::OPC_RD_RES | 8'(8 + 6 * c), 6, '0, v);
        chk(v, e);
        if (off(c))
        begin
            if (blk == 0 && q[c].size() == dep)
                skip[c] = 2;
            void'(q[c].pop_front());
            if (blk != 0 && q[c].size() == 0)
            begin
                drn[c] = 1'b0;
                skip[c] = 2;
            end
        end
        upd();
    endtask
    initial
    begin
        #990000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [47:0] v;
        void'($urandom(32'h30ae));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        chk(48'({miso_oe, pending_n}), 48'h1);
        axr(tdcf_pkg::REG_CTRL, d, r);
        chk(48'(d), 48'(tdcf_pkg::CTRL_RST));
        axw(8'h40, 32'h1, r);
        chk(48'(r), 48'(tdcf_pkg::RESP_SLVERR));
        axr(8'h40, d, r);
        chk(48'({d, r}), 48'(tdcf_pkg::RESP_SLVERR));
        $display("test registers done");
        cmd(tdcf_pkg::OPC_POWER, 0, '0, v);
        cmd(tdcf_pkg::OPC_WR_CFG | 8'h02, 2, 48'h5aa5, v);
        cmd(tdcf_pkg::OPC_RD_CFG | 8'h02, 2, '0, v);
        chk(v, 48'h5aa5);
        cmd(tdcf_pkg::OPC_RD_CFG | 8'h03, 1, '0, v);
        chk(v, 48'ha5);
        $display("test config done");
        for (int m = 0; m < 3; m++)
        begin
            mode(m, 0, 0);
            repeat (dep + 3) ev(0);
            ev(1);
            ck();
            cmd(tdcf_pkg::OPC_RD_RES | 8'h08, 5, '0, v);
            ck();
            rd(0);
            repeat (3) ev(0);
            ck();
            repeat (dep) rd(0);
            rd(1);
            rd(0);
            ck();
            $display("test depth %0d done", dep);
        end
        mode(0, 0, 1);
        ev(0);
        ck();
        for (int c = 1; c < 4; c++)
            ev(c);
        ck();
        for (int c = 0; c < 4; c++)
            rd(c);
        ck();
        $display("test joint drain done");
        mode(2, 1, 0);
        repeat (3) ev(0);
        ck();
        ev(0);
        ck();
        rd(0);
        ev(0);
        ck();
        repeat (3) rd(0);
        repeat (3) ev(0);
        ck();
        $display("test block drain done");
        wrap_up();
    end
endmodule // test_tdc_result_fifo_readout
